/* File: src/mpc_pin_control.sv */
// Purpose: Pin function and output enable control of the media port.
// Assumes: Pin inputs are synchronous to i_clk; APB slave with no waits.
// Notes:   Pin drives are registered, so they follow a setting by one cycle.
`timescale 1ns/1ns
`include "mpc_map.svh"

module mpc_pin_control
  import mpc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Display core.
  input wire logic i_ext_video_select,
  input wire logic i_int_blank,
  input wire logic i_int_hsync,
  input wire logic i_int_vsync,
  output logic o_dac_blank,
  output logic o_display_drive,
  output logic o_line_reference,
  output logic o_frame_start,
  output logic o_field_odd,
  output logic o_refill_irq,
  // Blank and sync pins.
  input wire logic i_blank_pin,
  output logic o_blank_pin,
  output logic o_blank_pin_oe,
  output logic o_hsync_out_pin,
  output logic o_hsync_out_pin_oe,
  output logic o_vsync_out_pin,
  output logic o_vsync_out_pin_oe,
  // Shared clock select and module host pins.
  input wire logic i_vref_mclk1_pin,
  output logic o_vref_mclk1_pin,
  output logic o_vref_mclk1_pin_oe,
  input wire logic i_serial_data_mclk2_pin,
  output logic o_serial_data_mclk2_pin,
  output logic o_serial_data_mclk2_pin_oe,
  input wire logic i_serial_clk_pin,
  output logic o_serial_clk_pin,
  output logic o_serial_clk_pin_oe,
  output logic [2:0] o_host_addr_pin,
  output logic o_host_rw_pin,
  output logic o_host_strobe_pin_n,
  input wire logic i_fifo_level_field_in,
  // General data pins.
  input wire logic i_gp_data0,
  output logic o_gp_data0,
  output logic o_gp_data0_oe,
  input wire logic i_gp_data1,
  output logic o_gp_data1,
  output logic o_gp_data1_oe,
  output logic o_gp_write_strobe,
  output logic o_gp_read_enable_n
);

  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must reach offset 0x31C");
  end

  mpc_cfg_t cfg;
  logic [5:0] pwr;
  logic [2:0] memclk_freq_select;
  logic [3:0] pixclk_freq_select;
  logic [7:0] seqx;
  logic gp_enable;
  logic por_pending;
  logic [2:0] host_addr;
  logic host_read;
  mpc_hc_state_t hc_state;
  mpc_hc_state_t next_hc_state;
  logic fifo_low;

  logic setup;
  logic access;
  logic wr;
  logic [11:0] addr;
  logic mapped;
  logic is_decoder;
  logic is_host_mode;
  logic target_ack_n;
  logic enabling_write;
  logic [31:0] next_rdata;

  mpc_pin_t next_blank;
  mpc_pin_t next_hsync;
  mpc_pin_t next_vsync;
  mpc_pin_t next_vref;
  mpc_pin_t next_sda;
  mpc_pin_t next_gp0;
  mpc_pin_t next_gp1;
  logic [2:0] next_host_addr;

  assign addr = 12'(i_paddr);
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite;
  assign o_pready = 1'b1;
  assign is_decoder = cfg.mode != MPC_MODE_FEATURE;
  assign is_host_mode = cfg.mode == MPC_MODE_MODULE ||
                        cfg.mode == MPC_MODE_MPEG;
  assign target_ack_n = i_gp_data0;

  always_comb begin
    unique case (addr)
      `MPC_OFF_CFG, `MPC_OFF_PWR, `MPC_OFF_MISC, `MPC_OFF_CLKSEL,
      `MPC_OFF_SEQX, `MPC_OFF_STATUS, `MPC_OFF_HOST,
      `MPC_OFF_SERIAL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign o_pslverr = access && !mapped;

  // Misc output, clock select and extended sequencer writes all arm the
  // data pins.
  assign enabling_write = wr && (addr == `MPC_OFF_MISC ||
                                 addr == `MPC_OFF_CLKSEL ||
                                 addr == `MPC_OFF_SEQX);

  // Configuration registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg <= mpc_cfg_t'(`MPC_RST_CFG);
      pwr <= `MPC_RST_PWR;
      memclk_freq_select <= 3'h0;
      pixclk_freq_select <= 4'h0;
    end else if (wr) begin
      if (addr == `MPC_OFF_CFG) begin
        cfg <= mpc_cfg_t'(i_pwdata[5:0]);
      end
      if (addr == `MPC_OFF_PWR) begin
        pwr <= i_pwdata[5:0];
      end
      if (addr == `MPC_OFF_CLKSEL) begin
        memclk_freq_select <= i_pwdata[`MPC_CLK_MEM_LO +: 3];
        pixclk_freq_select <= i_pwdata[`MPC_CLK_PIX_LO +: 4];
      end
    end
  end

  // Serial bus bits are shared by the sequencer and the serial port.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      seqx <= `MPC_RST_SEQX;
    end else if (wr && addr == `MPC_OFF_SEQX) begin
      seqx <= i_pwdata[7:0];
    end else if (wr && addr == `MPC_OFF_SERIAL) begin
      seqx[`MPC_SEQ_SCL] <= i_pwdata[`MPC_SER_SCL_W];
      seqx[`MPC_SEQ_SDA] <= i_pwdata[`MPC_SER_SDA_W];
    end
  end

  // Data pin 0 floats from reset until an enabling write arrives, and always in decoder mode; pin 1 until then or until stereo is set.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gp_enable <= 1'b0;
    end else if (enabling_write) begin
      gp_enable <= 1'b1;
    end
  end

  // Strobe pulses once after reset release and once per enabling write.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      por_pending <= 1'b1;
      o_gp_write_strobe <= 1'b0;
    end else begin
      por_pending <= 1'b0;
      o_gp_write_strobe <= por_pending || enabling_write;
    end
  end

  // FIFO low request; a new low level wins over a software clear.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fifo_low <= 1'b0;
    end else if (cfg.mode == MPC_MODE_MPEG && i_fifo_level_field_in) begin
      fifo_low <= 1'b1;
    end else if (wr && addr == `MPC_OFF_STATUS &&
                 i_pwdata[`MPC_ST_FIFO_LOW]) begin
      fifo_low <= 1'b0;
    end
  end

  // Host cycle sequencer toward the module or MPEG decoder.
  always_comb begin
    next_hc_state = hc_state;
    unique case (hc_state)
      MPC_HC_IDLE: begin
        if (wr && addr == `MPC_OFF_HOST && i_pwdata[`MPC_HOST_START] &&
            is_host_mode) begin
          next_hc_state = MPC_HC_SETUP;
        end
      end
      MPC_HC_SETUP: next_hc_state = MPC_HC_WAIT;
      MPC_HC_WAIT: begin
        if (!target_ack_n) begin
          next_hc_state = MPC_HC_END;
        end
      end
      MPC_HC_END: next_hc_state = MPC_HC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hc_state <= MPC_HC_IDLE;
      host_addr <= 3'h0;
      host_read <= 1'b1;
    end else begin
      hc_state <= next_hc_state;
      if (hc_state == MPC_HC_IDLE && next_hc_state == MPC_HC_SETUP) begin
        host_addr <= i_pwdata[`MPC_HOST_ADDR_LO +: 3];
        host_read <= i_pwdata[`MPC_HOST_READ];
      end
    end
  end

  // Pin drive selection.
  always_comb begin
    next_blank = '{val: i_int_blank, oe: 1'b0};
    next_hsync = '{val: i_int_hsync, oe: 1'b0};
    next_vsync = '{val: i_int_vsync, oe: 1'b0};
    next_vref = '{val: memclk_freq_select[1], oe: 1'b0};
    next_sda = '{val: 1'b0, oe: !seqx[`MPC_SEQ_SDA]};
    next_gp0 = '{val: seqx[`MPC_SEQ_GP0], oe: gp_enable};
    next_gp1 = '{val: seqx[`MPC_SEQ_GP1], oe: gp_enable};
    if (!is_decoder && i_ext_video_select) begin
      next_blank.oe = pwr[`MPC_PWR_BLANK_LO +: 2] != `MPC_PWR_TRISTATE;
      next_hsync.oe = pwr[`MPC_PWR_HSYNC_LO +: 2] != `MPC_PWR_TRISTATE;
      next_vsync.oe = pwr[`MPC_PWR_VSYNC_LO +: 2] != `MPC_PWR_TRISTATE;
    end
    if (is_decoder) begin
      next_hsync.oe = 1'b1;
      next_vsync.oe = 1'b1;
      next_gp0.oe = 1'b0;
    end
    if (cfg.ext_vcg) begin
      next_vref.oe = 1'b1;
      next_sda = '{val: memclk_freq_select[2], oe: 1'b1};
    end
    if (cfg.stereo) begin
      next_gp1.val = cfg.interlace && i_fifo_level_field_in;
      next_gp1.oe = 1'b1;
    end
  end

  // The three address pins share one mux per bit.
  for (genvar b = 0; b < 3; b++) begin : g_addr
    assign next_host_addr[b] = cfg.ext_pclk ? pixclk_freq_select[b] :
                               host_addr[b];
  end

  // Registered pin drivers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_blank_pin <= 1'b0;
      o_blank_pin_oe <= 1'b0;
      o_hsync_out_pin <= 1'b0;
      o_hsync_out_pin_oe <= 1'b0;
      o_vsync_out_pin <= 1'b0;
      o_vsync_out_pin_oe <= 1'b0;
    end else begin
      {o_blank_pin, o_blank_pin_oe} <= next_blank;
      {o_hsync_out_pin, o_hsync_out_pin_oe} <= next_hsync;
      {o_vsync_out_pin, o_vsync_out_pin_oe} <= next_vsync;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_vref_mclk1_pin <= 1'b0;
      o_vref_mclk1_pin_oe <= 1'b0;
      o_serial_data_mclk2_pin <= 1'b0;
      o_serial_data_mclk2_pin_oe <= 1'b0;
      o_serial_clk_pin <= 1'b0;
      o_serial_clk_pin_oe <= 1'b0;
      o_host_addr_pin <= 3'h0;
      o_host_rw_pin <= 1'b1;
      o_host_strobe_pin_n <= 1'b1;
    end else begin
      {o_vref_mclk1_pin, o_vref_mclk1_pin_oe} <= next_vref;
      {o_serial_data_mclk2_pin, o_serial_data_mclk2_pin_oe} <= next_sda;
      o_serial_clk_pin <= 1'b0;
      o_serial_clk_pin_oe <= !seqx[`MPC_SEQ_SCL];
      o_host_addr_pin <= next_host_addr;
      o_host_rw_pin <= cfg.ext_pclk ? pixclk_freq_select[3] :
                       host_read;
      o_host_strobe_pin_n <= cfg.ext_vcg ? memclk_freq_select[0] :
                             hc_state != MPC_HC_WAIT;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_gp_data0 <= 1'b0;
      o_gp_data0_oe <= 1'b0;
      o_gp_data1 <= 1'b0;
      o_gp_data1_oe <= 1'b0;
      o_gp_read_enable_n <= 1'b1;
    end else begin
      {o_gp_data0, o_gp_data0_oe} <= next_gp0;
      {o_gp_data1, o_gp_data1_oe} <= next_gp1;
      // Outside parties may only drive while neither pin is ours.
      o_gp_read_enable_n <= next_gp0.oe || next_gp1.oe;
    end
  end

  // Core side indications.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_dac_blank <= 1'b0;
      o_display_drive <= 1'b0;
      o_line_reference <= 1'b0;
      o_frame_start <= 1'b0;
      o_field_odd <= 1'b0;
      o_refill_irq <= 1'b0;
    end else begin
      o_dac_blank <= i_ext_video_select ? i_int_blank :
                     i_blank_pin;
      o_display_drive <= !is_decoder && i_ext_video_select;
      o_line_reference <= is_decoder && i_blank_pin;
      o_frame_start <= !cfg.ext_vcg && is_decoder &&
                       i_vref_mclk1_pin;
      if (cfg.mode == MPC_MODE_VDEC) begin
        o_field_odd <= i_fifo_level_field_in;
      end
      o_refill_irq <= fifo_low;
    end
  end

  // Read data is captured in the setup cycle so the access needs no wait.
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      `MPC_OFF_CFG: next_rdata[5:0] = cfg;
      `MPC_OFF_PWR: next_rdata[5:0] = pwr;
      `MPC_OFF_CLKSEL: begin
        next_rdata[`MPC_CLK_MEM_LO +: 3] = memclk_freq_select;
        next_rdata[`MPC_CLK_PIX_LO +: 4] = pixclk_freq_select;
      end
      `MPC_OFF_SEQX: next_rdata[7:0] = seqx;
      `MPC_OFF_STATUS: begin
        next_rdata[`MPC_ST_GP0] = i_gp_data0;
        next_rdata[`MPC_ST_GP1] = i_gp_data1;
        next_rdata[`MPC_ST_SCL] = i_serial_clk_pin;
        next_rdata[`MPC_ST_SDA] = i_serial_data_mclk2_pin;
        next_rdata[`MPC_ST_ODD] = o_field_odd;
        next_rdata[`MPC_ST_FIFO_LOW] = fifo_low;
        next_rdata[`MPC_ST_BUSY] = hc_state != MPC_HC_IDLE;
        next_rdata[`MPC_ST_GP_EN] = gp_enable;
      end
      `MPC_OFF_HOST: begin
        next_rdata[`MPC_HOST_ADDR_LO +: 3] = host_addr;
        next_rdata[`MPC_HOST_READ] = host_read;
      end
      `MPC_OFF_SERIAL: begin
        next_rdata[`MPC_SER_SCL_W] = seqx[`MPC_SEQ_SCL];
        next_rdata[`MPC_SER_SDA_W] = seqx[`MPC_SEQ_SDA];
        next_rdata[`MPC_SER_SCL_R] = i_serial_clk_pin;
        next_rdata[`MPC_SER_SDA_R] = i_serial_data_mclk2_pin;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      o_prdata <= next_rdata;
    end
  end

  // Checks.
  a_blank_tristate: assert property (@(posedge i_clk)
    disable iff (i_reset) (!is_decoder && i_ext_video_select &&
     pwr[1:0] == 2'h3) |=> !o_blank_pin_oe)
    else $error("blank pin driven with power field 11");

  a_hsync_decoder: assert property (@(posedge i_clk)
    disable iff (i_reset) is_decoder |=> o_hsync_out_pin_oe)
    else $error("hsync not enabled in decoder mode");

  a_vsync_select: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!is_decoder && !i_ext_video_select) |=> !o_vsync_out_pin_oe)
    else $error("vsync driven with video select low");

  a_scl_pull: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (wr && addr == 12'h31C && !i_pwdata[0]) |=> ##1 o_serial_clk_pin_oe)
    else $error("serial clock not pulled low");

  a_strobe_ack: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (hc_state == MPC_HC_WAIT && target_ack_n) |=> hc_state == MPC_HC_WAIT)
    else $error("host cycle ended without acknowledge");

  a_strobe_pin: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (!cfg.ext_vcg && hc_state == MPC_HC_WAIT) |=> !o_host_strobe_pin_n)
    else $error("strobe pin not low during wait");

  a_gp_float: assert property (@(posedge i_clk)
    disable iff (i_reset) !gp_enable |-> !o_gp_data0_oe)
    else $error("data pin 0 driven before enabling write");

  a_wstrobe_pulse: assert property (@(posedge i_clk)
    disable iff (i_reset) enabling_write |=> o_gp_write_strobe)
    else $error("write strobe missing after enabling write");

  a_stereo_low: assert property (@(posedge i_clk)
    disable iff (i_reset)
    (cfg.stereo && !cfg.interlace) |=> (o_gp_data1_oe && !o_gp_data1))
    else $error("stereo output not low when progressive");

  a_read_enable: assert property (@(posedge i_clk)
    disable iff (i_reset)
    !o_gp_read_enable_n |-> (!o_gp_data0_oe && !o_gp_data1_oe))
    else $error("read enable low while data pins driven");

endmodule

/* File: common/mpc_map.svh */
// Purpose: Register offsets, field positions and reset values of the
//          media port pin control block.
// Assumes: Byte addresses on a 32-bit APB data path.
// Notes:   Definitions only.
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH

// Register byte offsets.
`define MPC_OFF_CFG       12'h000
`define MPC_OFF_PWR       12'h004
`define MPC_OFF_MISC      12'h008
`define MPC_OFF_CLKSEL    12'h00C
`define MPC_OFF_SEQX      12'h010
`define MPC_OFF_STATUS    12'h014
`define MPC_OFF_HOST      12'h018
`define MPC_OFF_SERIAL    12'h31C

// Configuration register fields.
`define MPC_CFG_MODE_LO   0
`define MPC_CFG_EXTVCG    2
`define MPC_CFG_EXTPCLK   3
`define MPC_CFG_STEREO    4
`define MPC_CFG_INTERLACE 5

// Power management field positions and the tristate code.
`define MPC_PWR_BLANK_LO  0
`define MPC_PWR_HSYNC_LO  2
`define MPC_PWR_VSYNC_LO  4
`define MPC_PWR_TRISTATE  2'h3

// Clock select fields.
`define MPC_CLK_MEM_LO    0
`define MPC_CLK_PIX_LO    3

// Extended sequencer register bits.
`define MPC_SEQ_GP0       3
`define MPC_SEQ_GP1       4
`define MPC_SEQ_SCL       5
`define MPC_SEQ_SDA       6

// Serial port register bits.
`define MPC_SER_SCL_W     0
`define MPC_SER_SDA_W     1
`define MPC_SER_SCL_R     2
`define MPC_SER_SDA_R     3

// Status register bits.
`define MPC_ST_GP0        0
`define MPC_ST_GP1        1
`define MPC_ST_SCL        2
`define MPC_ST_SDA        3
`define MPC_ST_ODD        4
`define MPC_ST_FIFO_LOW   5
`define MPC_ST_BUSY       6
`define MPC_ST_GP_EN      7

// Host cycle register fields.
`define MPC_HOST_ADDR_LO  0
`define MPC_HOST_READ     8
`define MPC_HOST_START    9

// Reset values.
`define MPC_RST_CFG       6'h00
`define MPC_RST_PWR       6'h00
`define MPC_RST_CLKSEL    7'h00
`define MPC_RST_SEQX      8'h60

`endif

/* File: common/mpc_pkg.sv */
// Purpose: Types shared by the media port pin control block.
// Assumes: Nothing beyond the map header.
// Notes:   Pin drives travel as value and enable pairs.
package mpc_pkg;

  typedef enum logic [1:0] {
    MPC_MODE_FEATURE,
    MPC_MODE_MODULE,
    MPC_MODE_VDEC,
    MPC_MODE_MPEG
  } mpc_mode_t;

  typedef enum logic [1:0] {
    MPC_HC_IDLE,
    MPC_HC_SETUP,
    MPC_HC_WAIT,
    MPC_HC_END
  } mpc_hc_state_t;

  typedef struct packed {
    logic val;
    logic oe;
  } mpc_pin_t;

  typedef struct packed {
    logic interlace;
    logic stereo;
    logic ext_pclk;
    logic ext_vcg;
    mpc_mode_t mode;
  } mpc_cfg_t;

endpackage

/* File: test/mpc_target_model.sv */
// Purpose: Video module target that answers the block's host cycles.
// Assumes: Strobe and acknowledge are active low and sampled on i_clk.
// Notes:   Acknowledge idles high, where its pull-up leaves it.
`timescale 1ns/1ns
module mpc_target_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Host cycle pins.
  input wire logic i_strobe_n,
  input wire logic [3:0] i_delay,
  output logic o_ack_n
);
  logic [3:0] wait_cnt;

  // The target is slow on purpose: it holds off for the set delay so the
  // block must really wait, and lets go once the strobe rises.
  always_ff @(posedge i_clk) begin
    if (i_reset || i_strobe_n) begin
      wait_cnt <= 4'h0;
      o_ack_n <= 1'b1;
    end else if (wait_cnt >= i_delay) begin
      o_ack_n <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the media port pin control block.
// Assumes: Outputs are sampled at the rising edge, before it lands.
// Notes:   Pin inputs are resolved from the block's own enables.
`timescale 1ns/1ns
module tb_top;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, perr, i_ext_video_select = 1'b1;
  logic blank_ext = 1'b0, i_fifo_level_field_in = 1'b0, ack_n;
  logic int_blank = 1'b0, int_hsync = 1'b0, int_vsync = 1'b0;
  logic vref_ext = 1'b0;
  logic o_blank_pin, o_hsync_out_pin, o_vsync_out_pin, o_display_drive;
  logic o_frame_start;
  logic [3:0] dly = 4'h1;
  logic [6:0] v;
  logic [2:0] a;
  logic o_dac_blank, o_line_reference, o_field_odd, o_refill_irq;
  logic o_blank_pin_oe, o_hsync_out_pin_oe, o_vsync_out_pin_oe;
  logic o_vref_mclk1_pin, o_vref_mclk1_pin_oe, o_serial_clk_pin;
  logic o_serial_clk_pin_oe, o_serial_data_mclk2_pin, o_host_rw_pin;
  logic o_serial_data_mclk2_pin_oe, o_host_strobe_pin_n;
  logic [2:0] o_host_addr_pin;
  logic o_gp_data0, o_gp_data0_oe, o_gp_data1, o_gp_data1_oe;
  logic o_gp_write_strobe, o_gp_read_enable_n;
  wire i_blank_pin, i_vref_mclk1_pin, i_serial_clk_pin;
  wire i_serial_data_mclk2_pin, i_gp_data0, i_gp_data1;
  int error_cnt = 0;
  int tests_run = 0;
  int cnt;

  // Released open-drain lines float high on their pull-ups.
  assign i_serial_clk_pin = o_serial_clk_pin_oe ? o_serial_clk_pin : 1'b1;
  assign i_serial_data_mclk2_pin =
    o_serial_data_mclk2_pin_oe ? o_serial_data_mclk2_pin : 1'b1;
  assign i_blank_pin = o_blank_pin_oe ? o_blank_pin : blank_ext;
  // The video source drives the frame start while the pin is not ours.
  assign i_vref_mclk1_pin =
    o_vref_mclk1_pin_oe ? o_vref_mclk1_pin : vref_ext;
  assign i_gp_data0 = o_gp_data0_oe ? o_gp_data0 : ack_n;
  // The outside party drives data pin 1 only while read enable is low.
  assign i_gp_data1 = o_gp_data1_oe ? o_gp_data1 :
    (o_gp_read_enable_n ? 1'b1 : 1'b0);
  always #25 i_clk = ~i_clk;

  mpc_pin_control #(.ADDR_W(12)) DUT (
    .i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_ext_video_select,
    .i_int_blank(int_blank), .i_int_hsync(int_hsync),
    .i_int_vsync(int_vsync),
    .o_dac_blank, .o_display_drive, .o_line_reference,
    .o_frame_start, .o_field_odd, .o_refill_irq, .i_blank_pin,
    .o_blank_pin, .o_blank_pin_oe, .o_hsync_out_pin,
    .o_hsync_out_pin_oe, .o_vsync_out_pin, .o_vsync_out_pin_oe,
    .i_vref_mclk1_pin, .o_vref_mclk1_pin, .o_vref_mclk1_pin_oe,
    .i_serial_data_mclk2_pin, .o_serial_data_mclk2_pin,
    .o_serial_data_mclk2_pin_oe, .i_serial_clk_pin, .o_serial_clk_pin,
    .o_serial_clk_pin_oe, .o_host_addr_pin, .o_host_rw_pin,
    .o_host_strobe_pin_n, .i_fifo_level_field_in, .i_gp_data0,
    .o_gp_data0, .o_gp_data0_oe, .i_gp_data1, .o_gp_data1,
    .o_gp_data1_oe, .o_gp_write_strobe, .o_gp_read_enable_n);

  mpc_target_model PARTNER (.i_clk(i_clk), .i_reset(i_reset),
    .i_strobe_n(o_host_strobe_pin_n), .i_delay(dly), .o_ack_n(ack_n));

  task automatic results;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One APB transfer; the idle edge first keeps back-to-back calls apart.
  task automatic apb(input logic w, input logic [11:0] ad,
      input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      error_cnt++;
      results();
    end
    rd = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  initial begin
    wt(16);
    i_reset <= 1'b0;
    wt(2);
    chk("wstb_rst", 1, o_gp_write_strobe);
    chk("gp0_oe_rst", 0, o_gp_data0_oe);
    wt(1);
    chk("wstb_end", 0, o_gp_write_strobe);
    apb(1'b0, 12'h010, 32'h0);
    chk("seqx_rst", 32'h60, rd);
    apb(1'b1, 12'h008, 32'h0);
    wt(1);
    chk("misc_wstb", 1, o_gp_write_strobe);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", 1, perr);
    chk("unmapped_rd", 0, rd);
    for (int p = 0; p < 64; p++) begin
      apb(1'b1, 12'h004, p);
      wt(2);
      chk("blank_oe", p[1:0] != 2'h3, o_blank_pin_oe);
      chk("hsync_oe", p[3:2] != 2'h3, o_hsync_out_pin_oe);
      chk("vsync_oe", p[5:4] != 2'h3, o_vsync_out_pin_oe);
    end
    apb(1'b1, 12'h004, 32'h0);
    int_blank <= 1'b1;
    int_vsync <= 1'b1;
    wt(2);
    chk("drive", 2'b11, {o_display_drive, o_dac_blank});
    chk("blank_val", 1, o_blank_pin);
    chk("sync_val", 2'b01, {o_hsync_out_pin, o_vsync_out_pin});
    int_blank <= 1'b0;
    i_ext_video_select <= 1'b0;
    blank_ext <= 1'b1;
    wt(3);
    chk("blank_in", 2'b01, {o_blank_pin_oe, o_dac_blank});
    chk("sync_off", 0, {o_hsync_out_pin_oe, o_vsync_out_pin_oe});
    chk("drive_off", 0, o_display_drive);
    apb(1'b1, 12'h010, 32'h68);
    wt(1);
    chk("seq_wstb", 1, o_gp_write_strobe);
    wt(1);
    chk("gp0", 2'b11, {o_gp_data0_oe, o_gp_data0});
    chk("gp1", 2'b10, {o_gp_data1_oe, o_gp_data1});
    apb(1'b0, 12'h014, 32'h0);
    chk("st_pins", 4'hD, rd[3:0]);
    apb(1'b1, 12'h31C, 32'h0);
    wt(2);
    chk("scl_pull", 2'b10, {o_serial_clk_pin_oe, o_serial_clk_pin});
    chk("sda_pull", 1, o_serial_data_mclk2_pin_oe);
    apb(1'b0, 12'h31C, 32'h0);
    chk("ser_lvl", 4'h0, rd[3:0]);
    apb(1'b1, 12'h31C, 32'h3);
    apb(1'b1, 12'h010, 32'h48);
    wt(2);
    chk("scl_seq", 1, o_serial_clk_pin_oe);
    apb(1'b0, 12'h014, 32'h0);
    chk("st_lvl", 2'b10, rd[3:2]);
    apb(1'b1, 12'h000, 32'h0C);
    for (int k = 0; k < 2; k++) begin
      v = k ? 7'h2A : 7'h55;
      apb(1'b1, 12'h00C, {25'h0, v});
      wt(1);
      chk("clk_wstb", 1, o_gp_write_strobe);
      wt(1);
      chk("mclk0", v[0], o_host_strobe_pin_n);
      chk("mclk1", {1'b1, v[1]}, {o_vref_mclk1_pin_oe, o_vref_mclk1_pin});
      chk("mclk2", {1'b1, v[2]},
        {o_serial_data_mclk2_pin_oe, o_serial_data_mclk2_pin});
      chk("pclk", v[6:3], {o_host_rw_pin, o_host_addr_pin});
    end
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h004, 32'h3F);
    for (int f = 0; f < 2; f++) begin
      i_fifo_level_field_in <= f[0];
      blank_ext <= f[0];
      vref_ext <= f[0];
      wt(2);
      chk("frame", f, o_frame_start);
      chk("dec_sync", 2'b11, {o_hsync_out_pin_oe, o_vsync_out_pin_oe});
      chk("field", f, o_field_odd);
      chk("line_ref", f, o_line_reference);
    end
    apb(1'b1, 12'h000, 32'h3);
    wt(2);
    i_fifo_level_field_in <= 1'b0;
    wt(2);
    chk("irq_held", 1, o_refill_irq);
    apb(1'b1, 12'h014, 32'h20);
    wt(2);
    chk("irq_clr", 0, o_refill_irq);
    apb(1'b1, 12'h000, 32'h1);
    for (int c = 0; c < 2; c++) begin
      dly <= c ? 4'h6 : 4'h1;
      a = c ? 3'h2 : 3'h5;
      apb(1'b1, 12'h018, {22'h0, 1'b1, ~c[0], 5'h0, a});
      cnt = 0;
      repeat (40) begin
        @(posedge i_clk);
        if (o_host_strobe_pin_n === 1'b0) begin
          cnt++;
          chk("host", {~c[0], a}, {o_host_rw_pin, o_host_addr_pin});
        end
      end
      chk("stb_len", dly + 4'h3, cnt);
      apb(1'b0, 12'h014, 32'h0);
      chk("busy", 0, rd[6]);
    end
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h010, 32'h78);
    wt(2);
    chk("stereo", 2'b10, {o_gp_data1_oe, o_gp_data1});
    apb(1'b1, 12'h000, 32'h30);
    i_fifo_level_field_in <= 1'b1;
    wt(2);
    chk("stereo_odd", 2'b11, {o_gp_data1_oe, o_gp_data1});
    results();
  end
endmodule
